// ==== rtl/rsfs_consts.vh ====
// Constants for the reset sequencer and flash security block.
// Behaviour
// [RQ1] Software may disable stop and wait instructions; the disable clears at reset.
// [RQ2] Four reset sources: pin, power-on (async), software and watchdog (sync).
// [RQ3] Power-on reset is stretched for two to the twenty-first clock cycles.
// [RQ4] Then three 32-clock windows: clocking, peripherals and security, core.
// [RQ5] Reset asserts asynchronously but releases only on a rising clock edge; here every source asserts on a clock edge.
// [RQ6] Programmed security bytes keep the part secured across resets and power-down.
// [RQ7] Secured state comes from exactly two security bytes.
// [RQ8] When secured, on-chip debug is disabled; normal execution is unchanged.
// [RQ9] Boot selects unsecured mode or secure mode with debug port disabled.
// [RQ10] The chip-level test access port is active from boot.
// [RQ11] During reset the debug-read-disable follows the security bytes.
// [RQ12] Lockout recovery mass-erases flash, which clears the secured state.
// [RQ13] Recovery instruction selects a 7-bit divider data register.
// [RQ14] Divider bit 6 drives prescale-by-eight, bits 5 to 0 the divide field.
// [RQ15] Host picks divider so the divided flash clock is 150 to 200 kHz.
// [RQ16] Flash input clock is half system clock; prescale set above 12.8 MHz.
// [RQ17] Host loads instruction, shifts divider, idles; device erases to completion.
// [RQ18] After recovery host asserts TRST and chip reset to unsecure.
// [RQ19] Backdoor key unsecure is allowed only when the key enable bit is set.
// [RQ20] Programmer should write backdoor key, then code, then security bytes last.
// [RQ21] Software must shut the PLL down itself before stop mode.
// [RQ22] Debug-read-disable stays asserted from reset until security bytes are sampled.
`ifndef RSFS_CONSTS_VH
`define RSFS_CONSTS_VH
`define RSFS_POR_STRETCH_LOG2 21
`define RSFS_WINDOW_CYCLES 32
`define RSFS_CNT_W 22
`define RSFS_DIV_W 7
`define RSFS_DIV_PRESCALE_BIT 6
`define RSFS_DIV_FIELD_HI 5
`define RSFS_SEC_BYTE_W 8
`define RSFS_UNSECURE_LO 8'h02
`define RSFS_UNSECURE_HI 8'hff
`define RSFS_DIV_RESET 7'h00
`define RSFS_ERASE_CYCLES 22'h000100
`endif

// ==== rtl/rsfs_sync2.v ====
// Two flip-flop synchroniser for an asynchronous level.
module rsfs_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Level in and synchronised level out.
  input wire asyncIn,
  output reg syncOut
);
  reg stage1;

  // The first stage feeds only the second stage.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// ==== rtl/rsfs_reset_security.v ====
// Reset sequencer, flash security mode selection and lockout recovery control.
`include "rsfs_consts.vh"

module rsfs_reset_security #(
  parameter POR_STRETCH_CYCLES = (1 << `RSFS_POR_STRETCH_LOG2),
  parameter WINDOW_CYCLES = `RSFS_WINDOW_CYCLES,
  parameter ERASE_CYCLES = `RSFS_ERASE_CYCLES
) (
  // Clock, clock enable and reset.
  input wire ref_clk,
  input wire rst_n,
  input wire clkEn,
  // Asynchronous reset sources from pins.
  input wire extReset_n,
  input wire powerOnReset_n,
  // Synchronous reset sources and control from the core.
  input wire softwareReset,
  input wire watchdogReset,
  input wire stopDisableWrite,
  input wire stopDisableValue,
  input wire waitDisableWrite,
  input wire waitDisableValue,
  // Security bytes read from the flash configuration field.
  input wire [7:0] securityByteLo,
  input wire [7:0] securityByteHi,
  input wire backdoorKeyEnable,
  input wire backdoorKeyMatch,
  // Lockout recovery port from the test access port logic.
  input wire recoveryInstrSelected,
  input wire recoveryDrUpdate,
  input wire [6:0] recoveryDrValue,
  input wire tapRunTestIdle,
  input wire eraseDone,
  // Reset release and sequencing outputs.
  output reg clockingReset_n,
  output reg peripheralReset_n,
  output reg coreReset_n,
  output reg appRun,
  // Security outputs.
  output reg secured,
  output reg debugReadDisable,
  output reg debugPortEnable,
  output reg tapActive,
  // Stop and wait disables.
  output reg stopDisable,
  output reg waitDisable,
  // Flash clock divider override and erase control.
  output reg prescaleByEight,
  output reg [5:0] divideField,
  output reg dividerOverride,
  output reg massErase,
  output reg recoveryDone
);
  localparam ST_STRETCH = 3'h0;
  localparam ST_CLOCKING = 3'h1;
  localparam ST_PERIPH = 3'h2;
  localparam ST_CORE = 3'h3;
  localparam ST_RUN = 3'h4;

  localparam RC_IDLE = 2'h0;
  localparam RC_LOADED = 2'h1;
  localparam RC_ERASE = 2'h2;
  localparam RC_DONE = 2'h3;

  wire extResetSync_n;
  wire porSync_n;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [`RSFS_CNT_W-1:0] count;
  reg [`RSFS_CNT_W-1:0] next_count;
  reg porSeen;
  reg [1:0] recState;
  reg [`RSFS_DIV_W-1:0] divHold;
  reg [`RSFS_CNT_W-1:0] eraseCount;
  wire syncReset;
  wire bytesSecure;
  wire drLoad;

  // Decodes the two security bytes into a secured flag.
  function secureDecode;
    input [7:0] lo;
    input [7:0] hi;
    begin
      secureDecode = !((lo == `RSFS_UNSECURE_LO) && (hi == `RSFS_UNSECURE_HI)); // [RQ7]
    end
  endfunction

  // True once the sequencer has reached the given stage or any later one.
  function reachedStage;
    input [2:0] st;
    input [2:0] stage;
    begin
      reachedStage = (st >= stage) && (st <= ST_RUN);
    end
  endfunction

  // True on the last cycle of one of the fixed-length release windows.
  function windowEnd;
    input [`RSFS_CNT_W-1:0] cnt;
    begin
      windowEnd = (cnt == WINDOW_CYCLES - 1);
    end
  endfunction

  // The asynchronous pin sources are synchronised before use.
  rsfs_sync2 #(.RESET_VAL(1'b0)) uExtSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(extReset_n),
    .syncOut(extResetSync_n)
  );

  rsfs_sync2 #(.RESET_VAL(1'b0)) uPorSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(powerOnReset_n),
    .syncOut(porSync_n)
  );

  // Any source restarts the sequence; sources are combined per clock edge.
  assign syncReset = !extResetSync_n || !porSync_n || softwareReset || watchdogReset; // [RQ2]
  assign bytesSecure = secureDecode(securityByteLo, securityByteHi);

  // A divider update counts only while the recovery instruction is selected.
  assign drLoad = recoveryInstrSelected && recoveryDrUpdate; // [RQ13]

  // Next state of the reset sequencer with its window counter.
  always @* begin
    next_state = state;
    next_count = count + 1'b1;
    case (state)
      ST_STRETCH: begin
        // Only a power-on reset waits for the clock source to settle.
        if (!porSeen || count == POR_STRETCH_CYCLES - 1) begin // [RQ3]
          next_state = ST_CLOCKING;
          next_count = {`RSFS_CNT_W{1'b0}};
        end
      end
      ST_CLOCKING: begin
        if (windowEnd(count)) begin // [RQ4]
          next_state = ST_PERIPH;
          next_count = {`RSFS_CNT_W{1'b0}};
        end
      end
      ST_PERIPH: begin
        if (windowEnd(count)) begin // [RQ4]
          next_state = ST_CORE;
          next_count = {`RSFS_CNT_W{1'b0}};
        end
      end
      ST_CORE: begin
        if (windowEnd(count)) begin // [RQ4]
          next_state = ST_RUN;
          next_count = {`RSFS_CNT_W{1'b0}};
        end
      end
      ST_RUN: begin
        // The counter parks once the application runs.
        next_count = count;
      end
      default: begin
        next_state = ST_STRETCH;
        next_count = {`RSFS_CNT_W{1'b0}};
      end
    endcase
  end

  // Sequencer registers; releases happen only on a rising clock edge.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_STRETCH;
      count <= {`RSFS_CNT_W{1'b0}};
      porSeen <= 1'b1;
    end else if (clkEn) begin
      if (syncReset) begin
        state <= ST_STRETCH; // [RQ5]
        count <= {`RSFS_CNT_W{1'b0}};
        porSeen <= !porSync_n; // [RQ3]
      end else begin
        state <= next_state;
        count <= next_count;
      end
    end
  end

  // Reset outputs, mode selection and debug gating.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clockingReset_n <= 1'b0;
      peripheralReset_n <= 1'b0;
      coreReset_n <= 1'b0;
      appRun <= 1'b0;
      secured <= 1'b1;
      debugReadDisable <= 1'b1;
      debugPortEnable <= 1'b0;
      tapActive <= 1'b0;
    end else if (clkEn) begin
      if (syncReset) begin
        // Any source drops every domain back into reset at once.
        clockingReset_n <= 1'b0;
        peripheralReset_n <= 1'b0;
        coreReset_n <= 1'b0;
        appRun <= 1'b0;
        debugReadDisable <= 1'b1; // [RQ22]
        debugPortEnable <= 1'b0;
      end else begin
        // Each domain leaves reset at the start of its own window.
        clockingReset_n <= reachedStage(next_state, ST_CLOCKING); // [RQ4]
        peripheralReset_n <= reachedStage(next_state, ST_PERIPH); // [RQ4]
        coreReset_n <= reachedStage(next_state, ST_CORE); // [RQ4]
        appRun <= reachedStage(next_state, ST_RUN); // [RQ4]
        tapActive <= 1'b1; // [RQ10]
        // Security bytes are sampled during the peripheral window.
        if (state == ST_PERIPH) begin
          secured <= bytesSecure && !(backdoorKeyEnable && backdoorKeyMatch); // [RQ6] [RQ19]
          debugReadDisable <= bytesSecure; // [RQ11]
          debugPortEnable <= !bytesSecure; // [RQ8] [RQ9]
        // A matching backdoor key with its enable bit set unsecures a running part.
        end else if (state == ST_RUN && secured && backdoorKeyEnable && backdoorKeyMatch) begin
          secured <= 1'b0; // [RQ19]
          debugReadDisable <= 1'b0;
          debugPortEnable <= 1'b1;
        end
      end
    end
  end

  // Stop and wait disables; any reset clears them.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stopDisable <= 1'b0;
      waitDisable <= 1'b0;
    end else if (clkEn) begin
      if (syncReset) begin
        stopDisable <= 1'b0; // [RQ1]
        waitDisable <= 1'b0;
      end else begin
        if (stopDisableWrite) begin
          stopDisable <= stopDisableValue; // [RQ1]
        end
        if (waitDisableWrite) begin
          waitDisable <= waitDisableValue; // [RQ1]
        end
      end
    end
  end

  // Lockout recovery: divider capture, erase on idle entry, run to completion.
  // The secured flag is left alone here; the erased bytes are re-read at the next reset.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      recState <= RC_IDLE;
      divHold <= `RSFS_DIV_RESET;
      eraseCount <= {`RSFS_CNT_W{1'b0}};
      prescaleByEight <= 1'b0;
      divideField <= 6'h00;
      dividerOverride <= 1'b0;
      massErase <= 1'b0;
      recoveryDone <= 1'b0;
    end else if (clkEn) begin
      case (recState)
        RC_IDLE: begin
          if (drLoad) begin
            divHold <= recoveryDrValue; // [RQ13]
            recState <= RC_LOADED;
          end
        end
        RC_LOADED: begin
          // A later update before idle simply replaces the held divider.
          if (drLoad) begin
            divHold <= recoveryDrValue; // [RQ13]
          end else if (recoveryInstrSelected && tapRunTestIdle) begin
            prescaleByEight <= divHold[`RSFS_DIV_PRESCALE_BIT]; // [RQ14] [RQ16]
            divideField <= divHold[`RSFS_DIV_FIELD_HI:0]; // [RQ14]
            dividerOverride <= 1'b1;
            massErase <= 1'b1; // [RQ17]
            eraseCount <= {`RSFS_CNT_W{1'b0}};
            recState <= RC_ERASE;
          end else if (!recoveryInstrSelected) begin
            recState <= RC_IDLE;
          end
        end
        RC_ERASE: begin
          // The erase ends on the flash module's done flag or on the safety limit.
          eraseCount <= eraseCount + 1'b1;
          if (eraseDone || eraseCount == ERASE_CYCLES - 1) begin
            massErase <= 1'b0; // [RQ12]
            dividerOverride <= 1'b0;
            recoveryDone <= 1'b1;
            recState <= RC_DONE;
          end
        end
        RC_DONE: begin
          // Only a reset source returns the recovery logic to idle.
          if (syncReset) begin
            recoveryDone <= 1'b0; // [RQ18]
            recState <= RC_IDLE;
          end
        end
        default: begin
          recState <= RC_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== tb/rsfs_chk_sva.sv ====
// Checker for the reset sequencer and flash security block.
module rsfs_chk #(
  parameter ERASE_CYCLES = 22'h000100
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Observed inputs.
  input wire recoveryInstrSelected,
  input wire recoveryDrUpdate,
  input wire [6:0] recoveryDrValue,
  input wire tapRunTestIdle,
  input wire backdoorKeyEnable,
  input wire backdoorKeyMatch,
  input wire stopDisableWrite,
  input wire stopDisableValue,
  // Observed outputs.
  input wire clockingReset_n,
  input wire peripheralReset_n,
  input wire coreReset_n,
  input wire appRun,
  input wire secured,
  input wire debugReadDisable,
  input wire debugPortEnable,
  input wire tapActive,
  input wire stopDisable,
  input wire prescaleByEight,
  input wire [5:0] divideField,
  input wire dividerOverride,
  input wire massErase,
  input wire recoveryDone
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [6:0] lastDiv;
  reg [21:0] eraseCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Last accepted divider and the length of the running erase.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastDiv <= 7'h00;
      eraseCnt <= 22'h000000;
    end else begin
      if (recoveryInstrSelected && recoveryDrUpdate && !massErase && !recoveryDone)
        lastDiv <= recoveryDrValue;
      eraseCnt <= massErase ? eraseCnt + 22'h000001 : 22'h000000;
    end
  end
  property p_perWin; $rose(clockingReset_n) |-> ##32 $rose(peripheralReset_n); endproperty
  a_perWin: assert property (p_perWin) else $error("peripheral window length");
  property p_coreWin; $rose(peripheralReset_n) |-> ##32 $rose(coreReset_n); endproperty
  a_coreWin: assert property (p_coreWin) else $error("core window length");
  property p_runWin; $rose(coreReset_n) |-> ##32 ($rose(appRun) && peripheralReset_n); endproperty
  a_runWin: assert property (p_runWin) else $error("run window length");
  property p_runAll; appRun |-> clockingReset_n && peripheralReset_n && tapActive; endproperty
  a_runAll: assert property (p_runAll) else $error("run before release");
  property p_secDbg; secured |-> !debugPortEnable; endproperty
  a_secDbg: assert property (p_secDbg) else $error("debug open while secured");
  property p_rdEarly; !peripheralReset_n |-> debugReadDisable; endproperty
  a_rdEarly: assert property (p_rdEarly) else $error("read disable dropped early");
  property p_divMap; dividerOverride |-> {prescaleByEight, divideField} == lastDiv; endproperty
  a_divMap: assert property (p_divMap) else $error("divider mapping");
  property p_eraseGo; $rose(massErase) |-> $past(tapRunTestIdle) && dividerOverride; endproperty
  a_eraseGo: assert property (p_eraseGo) else $error("erase without idle");
  property p_eraseEnd; $fell(massErase) |-> recoveryDone && eraseCnt <= ERASE_CYCLES; endproperty
  a_eraseEnd: assert property (p_eraseEnd) else $error("erase end");
  property p_key; $fell(secured) && appRun |-> $past(backdoorKeyEnable && backdoorKeyMatch);
  endproperty
  a_key: assert property (p_key) else $error("unsecured without key enable");
  property p_stop; stopDisableWrite |=> stopDisable == $past(stopDisableValue); endproperty
  a_stop: assert property (p_stop) else $error("stop disable load");
  c_run: cover property ($rose(appRun));
  c_erase: cover property ($rose(massErase));
  c_done: cover property ($rose(recoveryDone));
endmodule

bind rsfs_reset_security rsfs_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.*);

// ==== tb/rsfs_jtag_host.sv ====
// Debug host model that walks the test port through lockout recovery.
module rsfs_jtag_host (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Commands from the bench.
  input wire go,
  input wire trst,
  input wire [6:0] divVal,
  // Recovery port towards the device.
  output reg recoveryInstrSelected,
  output reg recoveryDrUpdate,
  output reg [6:0] recoveryDrValue,
  output reg tapRunTestIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [2:0] step;
  // Instruction, then divider update, then idle held until the tap is reset.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step <= 3'h0;
      recoveryInstrSelected <= 1'b0;
      recoveryDrUpdate <= 1'b0;
      recoveryDrValue <= 7'h55;
      tapRunTestIdle <= 1'b0;
    end else if (trst) begin
      step <= 3'h0;
      recoveryInstrSelected <= 1'b0;
      tapRunTestIdle <= 1'b0;
    end else begin
      recoveryDrUpdate <= 1'b0;
      // Shift data is not held outside its update cycle.
      recoveryDrValue <= ~recoveryDrValue;
      if (go && step == 3'h0) recoveryInstrSelected <= 1'b1;
      if (go && step == 3'h0) step <= 3'h1;
      if (step == 3'h1) begin
        recoveryDrUpdate <= 1'b1;
        recoveryDrValue <= divVal;
      end
      if (step == 3'h3) tapRunTestIdle <= 1'b1;
      if (step != 3'h0 && step != 3'h4) step <= step + 3'h1;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the reset sequencer and flash security block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, extReset_n = 1, powerOnReset_n = 1, eraseDone = 0;
  logic softwareReset = 0, watchdogReset = 0, stopDisableWrite = 0, stopDisableValue = 0;
  logic waitDisableWrite = 0, waitDisableValue = 0, backdoorKeyEnable = 0;
  logic backdoorKeyMatch = 0, go = 0, trst = 0;
  logic [7:0] securityByteLo = 8'h02, securityByteHi = 8'hff;
  logic [6:0] divVal = 7'h00;
  wire [6:0] recoveryDrValue;
  wire [5:0] divideField;
  wire recoveryInstrSelected, recoveryDrUpdate, tapRunTestIdle, clockingReset_n, appRun;
  wire peripheralReset_n, coreReset_n, secured, debugReadDisable, debugPortEnable, tapActive;
  wire stopDisable, waitDisable, prescaleByEight, dividerOverride, massErase, recoveryDone;
  int err_count = 0, n_checks = 0, n;
  rsfs_reset_security #(.POR_STRETCH_CYCLES(22'h000040), .ERASE_CYCLES(22'h000010)) u_dut (
    .*, .clkEn(1'b1));
  rsfs_jtag_host u_host (.*);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #5;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for run, erase or done; the count of cycles comes back in n.
  task automatic waitOn(input int k);
    for (n = 0; (k == 0 ? appRun : k == 1 ? massErase : recoveryDone) !== 1'b1; n++) begin
      if (n > 600) begin
        err_count++;
        end_sim();
      end
      tick(1);
    end
  endtask
  task automatic tBoot();
    chk({appRun, secured, debugReadDisable, debugPortEnable, tapActive}, 8'h0c);
    rst_n = 1;
    waitOn(0);
    chk(n >= 128, 1);
    chk({secured, debugPortEnable, tapActive, debugReadDisable}, 8'h06);
  endtask
  task automatic tSecure();
    securityByteLo = 8'h00; // Security bytes are set first, before the backdoor key is enabled.
    for (int s = 0; s < 3; s++) begin
      {stopDisableWrite, stopDisableValue, waitDisableWrite, waitDisableValue} = 4'hf;
      tick(1);
      {stopDisableWrite, waitDisableWrite} = 2'b00;
      chk({stopDisable, waitDisable}, 8'h03);
      {softwareReset, watchdogReset, powerOnReset_n} = s == 0 ? 3'b101 : s == 1 ? 3'b011 : 3'b000;
      tick(s == 2 ? 3 : 1);
      {softwareReset, watchdogReset, powerOnReset_n} = 3'b001;
      tick(2);
      chk({appRun, stopDisable, waitDisable}, 8'h00);
      waitOn(0);
      chk({n >= 60, n >= 124}, s == 2 ? 8'h03 : 8'h02);
      chk({secured, debugPortEnable, debugReadDisable}, 8'h05);
    end
  endtask
  task automatic tBackdoor();
    backdoorKeyMatch = 1;
    tick(4);
    chk(secured, 1);
    backdoorKeyEnable = 1;
    tick(4);
    chk({secured, debugPortEnable}, 8'h01);
    {backdoorKeyEnable, backdoorKeyMatch, softwareReset} = 3'b001;
    tick(1);
    softwareReset = 0;
    tick(2);
    waitOn(0);
    chk(secured, 1);
  endtask
  task automatic tRecovery();
    divVal = 7'h3b; // 10 MHz flash input stays unprescaled; 10 MHz / 60 is 167 kHz.
    go = 1;
    waitOn(1);
    chk({dividerOverride, prescaleByEight, divideField}, 8'hbb);
    waitOn(2);
    chk(n <= 18, 1);
    {go, trst, extReset_n, securityByteLo} = {3'b010, 8'h02};
    tick(3);
    {trst, extReset_n} = 2'b01;
    tick(2);
    waitOn(0);
    chk({secured, debugPortEnable, recoveryDone, dividerOverride}, 8'h04);
    go = 1;
    waitOn(1);
    eraseDone = 1;
    tick(1);
    eraseDone = 0;
    chk({massErase, recoveryDone, dividerOverride}, 8'h02);
  endtask
  initial begin
    tick(12);
    tBoot();
    tSecure();
    tBackdoor();
    tRecovery();
    end_sim();
  end
endmodule
